// ---- bglue_top.sv ----
// Board glue register bank: four byte registers on the host memory bus plus glue logic.
// Functional notes
// - The register window sits at byte 0x90080000 in the second chip-enable space.
// - Registers are 8 bits wide at offsets 0, 1, 4 and 6 of the window.
// - The top host address bit selects the registers (1) or the flash in the lower half (0).
// - User register bits 7 to 4 read the DIP switches, 1 for off and 0 for on.
// - User register bits 3 to 0 are read/write lamp controls, 1 lights, reset 0.
// - Card register bit 7 reads 1 with a card present and bits 6 and 2 read 0.
// - Card register bits 5 and 4 read the live card status inputs.
// - Card register bits 1 and 0 drive the card control outputs and reset low.
// - The card reset output is held low during the host processor reset and releases three clocks after it.
// - Card register bit 3 holds the card in reset when 1 and powers up 0.
// - The revision register is read-only with logic revision, a zero and board revision.
// - Each serial port goes to the codec when its route bit is 0, else to the connector.
// - Both route bits power up 0 so both ports start on the codec.
// - Misc bit 2 resets 0 and drives the flash address line A19 continuously.
// - Misc bits 7 to 3 are spare read/write storage reset to 0.
// - The push button and supply supervisor resets merge into one board reset.
module bglue_top #(
  parameter logic [3:0] LOGIC_REVISION = 4'h1, // Arbitrary value.
  parameter logic [2:0] BOARD_REVISION = 3'h1  // Arbitrary value.
) (
  // Clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               rst_n_i,
  // Host memory bus, asynchronous mode, active-low strobes
  input  wire logic [bglue_pkg::BGLUE_ADDR_W-1:0] host_addr_i,
  input  wire logic                               host_ce_n_i,
  input  wire logic                               host_re_n_i,
  input  wire logic                               host_we_n_i,
  input  wire logic [7:0]                         host_wdata_i,
  output logic      [7:0]                         host_rdata_o,
  output logic                                    host_rdata_oe_o,
  // Flash selects
  output logic                                    flash_ce_n_o,
  output logic                                    flash_a19_o,
  // User switches and lamps
  input  wire logic [3:0]                         dip_switch_i,
  output logic      [3:0]                         lamp_o,
  // Daughter card
  input  wire logic                               card_present_n_i,
  input  wire logic [1:0]                         card_status_i,
  output logic      [1:0]                         card_control_o,
  output logic                                    card_reset_out_n_o,
  // Serial port routing
  output logic                                    audio_ctrl_port_route_o,
  output logic                                    audio_data_port_route_o,
  // Reset glue
  input  wire logic                               button_rst_n_i,
  input  wire logic                               supply_ok_n_i,
  output logic                                    board_rst_n_o
);

  import bglue_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset merge and pin synchronisers.

  logic       rst_n;
  logic       board_rst_n;
  logic [BGLUE_ADDR_W+2:0] bus_s;
  logic [7:0] pin_s;

  bglue_rst u_rst (
    .clk_i          (clk_i),
    .rst_n_i        (rst_n_i),
    .button_rst_n_i (button_rst_n_i),
    .supply_ok_n_i  (supply_ok_n_i),
    .local_rst_n_o  (rst_n),
    .board_rst_n_o  (board_rst_n)
  );

  bglue_sync #(.WIDTH(BGLUE_ADDR_W + 3)) u_bus_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     ({~host_ce_n_i, ~host_re_n_i, ~host_we_n_i, host_addr_i}),
    .q_o     (bus_s)
  );

  bglue_sync #(.WIDTH(8)) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     ({~card_present_n_i, card_status_i, dip_switch_i, 1'b0}),
    .q_o     (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic                    ce_s;
  logic                    re_s;
  logic                    we_s;
  logic [BGLUE_ADDR_W-1:0] addr_s;
  logic                    reg_sel;
  logic [2:0]              ofs;
  logic [7:0]              wdata_q;

  assign ce_s    = bus_s[BGLUE_ADDR_W+2];
  assign re_s    = bus_s[BGLUE_ADDR_W+1];
  assign we_s    = bus_s[BGLUE_ADDR_W];
  assign addr_s  = bus_s[BGLUE_ADDR_W-1:0];
  assign reg_sel = ce_s & addr_s[BGLUE_SEL_BIT];
  assign ofs     = addr_s[2:0];

  // Write data passes two flops like the strobes, so it has settled before the write acts.
  bglue_sync #(.WIDTH(8)) u_data_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     (host_wdata_i),
    .q_o     (wdata_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write strobe state: one register update per host write strobe.

  bglue_bus_state_type state_q;
  bglue_bus_state_type state_d;
  logic                wr_fire;

  always_comb begin
    state_d = state_q;
    wr_fire = 1'b0;
    unique case (state_q)
      BGLUE_IDLE: begin
        if (reg_sel && we_s) begin
          state_d = BGLUE_WRITE;
        end
      end
      BGLUE_WRITE: begin
        wr_fire = 1'b1;
        state_d = BGLUE_HOLD;
      end
      BGLUE_HOLD: begin
        if (!we_s) begin
          state_d = BGLUE_IDLE;
        end
      end
      default: begin
        state_d = BGLUE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BGLUE_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [3:0] lamp_q;
  logic [3:0] lamp_d;
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic       hold_q;
  logic       hold_d;
  logic [7:0] misc_q;
  logic [7:0] misc_d;

  always_comb begin
    lamp_d = lamp_q;
    ctrl_d = ctrl_q;
    hold_d = hold_q;
    misc_d = misc_q;
    if (wr_fire) begin
      unique case (ofs)
        BGLUE_OFS_USER: lamp_d = wdata_q[3:0];
        BGLUE_OFS_CARD: begin
          ctrl_d = wdata_q[1:0];
          hold_d = wdata_q[BGLUE_CARD_RST];
        end
        BGLUE_OFS_MISC: misc_d = wdata_q;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lamp_q <= BGLUE_LAMP_RST;
      ctrl_q <= BGLUE_CTRL_RST;
      hold_q <= BGLUE_HOLD_RST;
      misc_q <= BGLUE_MISC_RST;
    end else begin
      lamp_q <= lamp_d;
      ctrl_q <= ctrl_d;
      hold_q <= hold_d;
      misc_q <= misc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and registered outputs.

  logic [7:0] user_rd;
  logic [7:0] card_rd;
  logic [7:0] rev_rd;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic       roe_d;
  logic       roe_q;
  logic       flash_ce_n_d;
  logic       flash_ce_n_q;
  logic [7:0] out_d;
  logic [7:0] out_q;
  logic       card_rst_n_d;
  logic       card_rst_n_q;
  logic       board_rst_d;
  logic       board_rst_q;

  // Fixed zero bits live only in these read words, so no write can ever set them.
  assign user_rd = {pin_s[4:1], lamp_q};
  assign card_rd = {pin_s[7], 1'b0, pin_s[6:5], hold_q, 1'b0, ctrl_q};
  assign rev_rd  = {LOGIC_REVISION, 1'b0, BOARD_REVISION};

  // Read word and enable come from one synchronised address sample, so they always agree.
  always_comb begin
    roe_d        = reg_sel & re_s;
    flash_ce_n_d = ~(ce_s & ~addr_s[BGLUE_SEL_BIT]);
    out_d        = {lamp_q, ctrl_q, misc_q[1:0]};
    card_rst_n_d = ~hold_q;
    board_rst_d  = board_rst_n;
    unique case (ofs)
      BGLUE_OFS_USER: rdata_d = user_rd;
      BGLUE_OFS_CARD: rdata_d = card_rd;
      BGLUE_OFS_REV:  rdata_d = rev_rd;
      BGLUE_OFS_MISC: rdata_d = misc_q;
      default:        rdata_d = BGLUE_UNMAPPED;
    endcase
  end

  // Reads have no side effect, so a read may be sampled as often as it likes.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q      <= 8'h00;
      roe_q        <= 1'b0;
      flash_ce_n_q <= 1'b1;
      out_q        <= 8'h00;
      card_rst_n_q <= 1'b0;
      board_rst_q  <= 1'b0;
    end else begin
      rdata_q      <= rdata_d;
      roe_q        <= roe_d;
      flash_ce_n_q <= flash_ce_n_d;
      out_q        <= out_d;
      card_rst_n_q <= card_rst_n_d;
      board_rst_q  <= board_rst_d;
    end
  end

  // The flash page bit bypasses the output stage so it tracks the register directly.
  assign flash_a19_o             = misc_q[BGLUE_MISC_PAGE];
  assign host_rdata_o            = rdata_q;
  assign host_rdata_oe_o         = roe_q;
  assign flash_ce_n_o            = flash_ce_n_q;
  assign lamp_o                  = out_q[7:4];
  assign card_control_o          = out_q[3:2];
  assign audio_data_port_route_o = out_q[1];
  assign audio_ctrl_port_route_o = out_q[0];
  assign card_reset_out_n_o      = card_rst_n_q;
  assign board_rst_n_o           = board_rst_q;

endmodule : bglue_top

// ---- bglue_pkg.sv ----
// Package of register offsets, field positions and reset values for the board glue block.
package bglue_pkg;

  localparam logic [31:0] BGLUE_WINDOW_BASE  = 32'h9008_0000;
  localparam int          BGLUE_ADDR_W       = 22;
  localparam int          BGLUE_SEL_BIT      = 21;
  localparam logic [2:0]  BGLUE_OFS_USER     = 3'h0;
  localparam logic [2:0]  BGLUE_OFS_CARD     = 3'h1;
  localparam logic [2:0]  BGLUE_OFS_REV      = 3'h4;
  localparam logic [2:0]  BGLUE_OFS_MISC     = 3'h6;
  localparam int          BGLUE_CARD_PRES    = 7;
  localparam int          BGLUE_CARD_RST     = 3;
  localparam int          BGLUE_MISC_PAGE    = 2;
  localparam logic [3:0]  BGLUE_LAMP_RST     = 4'h0;
  localparam logic [1:0]  BGLUE_CTRL_RST     = 2'h0;
  localparam logic        BGLUE_HOLD_RST     = 1'b0;
  localparam logic [7:0]  BGLUE_MISC_RST     = 8'h00;
  localparam logic [7:0]  BGLUE_UNMAPPED     = 8'h00;

  typedef enum logic [1:0] {
    BGLUE_IDLE,
    BGLUE_WRITE,
    BGLUE_HOLD
  } bglue_bus_state_type;

endpackage : bglue_pkg

// ---- bglue_sync.sv ----
// Two-stage synchroniser for a vector of asynchronous pin inputs.
module bglue_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule : bglue_sync

// ---- bglue_rst.sv ----
// Reset merge and release stage for the board glue block.
module bglue_rst (
  // Clock and raw resets
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic button_rst_n_i,
  input  wire logic supply_ok_n_i,
  // Merged resets
  output logic      local_rst_n_o,
  output logic      board_rst_n_o
);

  logic [1:0] local_q;
  logic [1:0] board_q;
  logic       board_src_n;

  // The host reset, the push button or an unhealthy supply forces the board reset.
  assign board_src_n = rst_n_i & button_rst_n_i & ~supply_ok_n_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      local_q <= 2'h0;
    end else begin
      local_q <= {local_q[0], 1'b1};
    end
  end

  // Assertion is immediate, release passes two flops to stay glitch free.
  always_ff @(posedge clk_i or negedge board_src_n) begin
    if (!board_src_n) begin
      board_q <= 2'h0;
    end else begin
      board_q <= {board_q[0], 1'b1};
    end
  end

  assign local_rst_n_o = local_q[1];
  assign board_rst_n_o = board_q[1];

endmodule : bglue_rst

// ---- bglue_checker.sv ----
// Concurrent checks on the ports of the board glue block.
module bglue_checker #(
  parameter logic [3:0] LOGIC_REVISION = 4'h1,
  parameter logic [2:0] BOARD_REVISION = 3'h1
) (
  // Clock and reset
  input wire logic                               clk_i,
  input wire logic                               rst_n_i,
  // Host bus
  input wire logic [bglue_pkg::BGLUE_ADDR_W-1:0] host_addr_i,
  input wire logic                               host_ce_n_i,
  input wire logic                               host_re_n_i,
  input wire logic                               host_we_n_i,
  input wire logic [7:0]                         host_rdata_o,
  input wire logic                               host_rdata_oe_o,
  // Glue outputs
  input wire logic                               flash_ce_n_o,
  input wire logic                               flash_a19_o,
  input wire logic [3:0]                         lamp_o,
  input wire logic [1:0]                         card_control_o,
  input wire logic                               card_reset_out_n_o,
  input wire logic                               audio_ctrl_port_route_o,
  input wire logic                               audio_data_port_route_o,
  input wire logic                               button_rst_n_i,
  input wire logic                               supply_ok_n_i,
  input wire logic                               board_rst_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import bglue_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // A register read that is being answered at the given offset.
  sequence s_rd(logic hit);
    host_rdata_oe_o && !host_re_n_i && host_addr_i[BGLUE_SEL_BIT] && hit;
  endsequence
  property p_zero;
    s_rd(host_addr_i[2:0] == BGLUE_OFS_CARD) |-> !host_rdata_o[6] && !host_rdata_o[2];
  endproperty
  a_zero: assert property (p_zero) else $error("card zero bits set");
  property p_card;
    s_rd(host_addr_i[2:0] == BGLUE_OFS_CARD)
      |-> host_rdata_o[1:0] == card_control_o && host_rdata_o[3] == !card_reset_out_n_o;
  endproperty
  a_card: assert property (p_card) else $error("card controls differ");
  property p_rev;
    s_rd(host_addr_i[2:0] == BGLUE_OFS_REV)
      |-> host_rdata_o == {LOGIC_REVISION, 1'b0, BOARD_REVISION};
  endproperty
  a_rev: assert property (p_rev) else $error("revision wrong");
  property p_misc;
    s_rd(host_addr_i[2:0] == BGLUE_OFS_MISC) |-> host_rdata_o[2:0]
      == {flash_a19_o, audio_data_port_route_o, audio_ctrl_port_route_o};
  endproperty
  a_misc: assert property (p_misc) else $error("routing differs");
  property p_unm;
    s_rd(host_addr_i[2:0] inside {3'h2, 3'h3, 3'h5, 3'h7}) |-> host_rdata_o == BGLUE_UNMAPPED;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read wrong");
  property p_lamp;
    !$stable(lamp_o) |-> !$past(host_we_n_i, 2) && $past(host_addr_i[2:0], 2) == BGLUE_OFS_USER;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamps moved unwritten");
  property p_flash;
    (!host_ce_n_i && !host_addr_i[BGLUE_SEL_BIT]) [*5] |-> !flash_ce_n_o && !host_rdata_oe_o;
  endproperty
  a_flash: assert property (p_flash) else $error("flash not selected");
  property p_noflash;
    (host_ce_n_i || host_addr_i[BGLUE_SEL_BIT]) [*5] |-> flash_ce_n_o;
  endproperty
  a_noflash: assert property (p_noflash) else $error("flash wrongly selected");
  property p_crst;
    $rose(rst_n_i) |-> !card_reset_out_n_o ##[2:4] card_reset_out_n_o;
  endproperty
  a_crst: assert property (p_crst) else $error("card reset not released");
  property p_board;
    (!button_rst_n_i || supply_ok_n_i) |-> ##[0:3] !board_rst_n_o;
  endproperty
  a_board: assert property (p_board) else $error("board reset missed");
endmodule : bglue_checker

bind bglue_top bglue_checker #(.LOGIC_REVISION(LOGIC_REVISION), .BOARD_REVISION(BOARD_REVISION))
  bglue_checker_inst (.clk_i, .rst_n_i, .host_addr_i, .host_ce_n_i, .host_re_n_i, .host_we_n_i,
  .host_rdata_o, .host_rdata_oe_o, .flash_ce_n_o, .flash_a19_o, .lamp_o, .card_control_o,
  .card_reset_out_n_o, .audio_ctrl_port_route_o, .audio_data_port_route_o, .button_rst_n_i,
  .supply_ok_n_i, .board_rst_n_o);

// ---- bglue_host.sv ----
// Host processor model issuing asynchronous memory reads and writes.
module bglue_host (
  // Clock
  input  wire logic        clk_i,
  // Host bus
  output logic      [21:0] host_addr_o,
  output logic             host_ce_n_o,
  output logic             host_re_n_o,
  output logic             host_we_n_o,
  output logic      [7:0]  host_wdata_o,
  input  wire logic [7:0]  host_rdata_i,
  input  wire logic        host_rdata_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host_addr_o = 22'h3FFFFF;
    host_ce_n_o = 1'b1;
    host_re_n_o = 1'b1;
    host_we_n_o = 1'b1;
    host_wdata_o = 8'h00;
  end
  // Plain strobed cycles; there is no ready line, so writes hold a fixed time.
  task automatic acc(input logic wr, input logic [21:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic ok);
    int n;
    @(negedge clk_i);
    host_addr_o = a;
    host_wdata_o = d;
    host_ce_n_o = 1'b0;
    host_we_n_o = !wr;
    host_re_n_o = wr;
    ok = wr;
    q = 8'h00;
    for (n = 0; n < 8 && !wr; n++) begin
      @(posedge clk_i);
      if (host_rdata_oe_i === 1'b1) begin
        q = host_rdata_i;
        ok = 1'b1;
        break;
      end
    end
    if (wr) repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    host_ce_n_o = 1'b1;
    host_we_n_o = 1'b1;
    host_re_n_o = 1'b1;
    host_wdata_o = ~d;
    repeat (5) @(negedge clk_i);
  endtask : acc
endmodule : bglue_host

// ---- test_bglue_top.sv ----
// Self-checking testbench of the board glue register bank.
module test_bglue_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bglue_pkg::*;
  logic clk, rst_n, ce_n, re_n, we_n, oe, fl_n, a19, pres_n, crst_n, rt_c, rt_d, btn_n, sup_n;
  logic [21:0] addr;
  logic [7:0] wd, rdat;
  logic [3:0] dip, lamp;
  logic [1:0] stat, ctl;
  logic board_n;
  int errors = 0;
  int cmp_count = 0;
  bglue_top #(.LOGIC_REVISION(4'hC), .BOARD_REVISION(3'h5)) bglue_top_inst (.clk_i(clk),
    .rst_n_i(rst_n), .host_addr_i(addr), .host_ce_n_i(ce_n), .host_re_n_i(re_n),
    .host_we_n_i(we_n), .host_wdata_i(wd), .host_rdata_o(rdat), .host_rdata_oe_o(oe),
    .flash_ce_n_o(fl_n), .flash_a19_o(a19), .dip_switch_i(dip), .lamp_o(lamp),
    .card_present_n_i(pres_n), .card_status_i(stat), .card_control_o(ctl),
    .card_reset_out_n_o(crst_n), .audio_ctrl_port_route_o(rt_c), .audio_data_port_route_o(rt_d),
    .button_rst_n_i(btn_n), .supply_ok_n_i(sup_n), .board_rst_n_o(board_n));
  bglue_host bglue_host_inst (.clk_i(clk), .host_addr_o(addr), .host_ce_n_o(ce_n),
    .host_re_n_o(re_n), .host_we_n_o(we_n), .host_wdata_o(wd), .host_rdata_i(rdat),
    .host_rdata_oe_i(oe));
  //////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] o, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    bglue_host_inst.acc(1'b1, {1'b1, 18'h0, o}, d, q, ok);
  endtask : wr
  task automatic rchk(input logic [2:0] o, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    bglue_host_inst.acc(1'b0, {1'b1, 18'h0, o}, 8'h00, q, ok);
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t read not answered", $time);
      finish_test();
    end
    chk(q, e);
  endtask : rchk
  //////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(BGLUE_OFS_USER, 8'hF0);
    rchk(BGLUE_OFS_CARD, 8'h00);
    rchk(BGLUE_OFS_MISC, BGLUE_MISC_RST);
    chk({crst_n, rt_d, rt_c, a19, ctl, fl_n, 1'b0}, 8'h82);
  endtask : t_reset
  task automatic t_user_card();
    dip = 4'h5;
    pres_n = 1'b0;
    stat = 2'b10;
    wr(BGLUE_OFS_USER, 8'hFA);
    rchk(BGLUE_OFS_USER, 8'h5A);
    wr(BGLUE_OFS_CARD, 8'hFF);
    rchk(BGLUE_OFS_CARD, 8'hAB);
    chk({lamp, 1'b0, crst_n, ctl}, 8'hA3);
    wr(BGLUE_OFS_CARD, 8'h00);
    pres_n = 1'b1;
    stat = 2'b01;
    rchk(BGLUE_OFS_CARD, 8'h10);
    chk({crst_n, ctl}, 8'h04);
  endtask : t_user_card
  task automatic t_regs();
    logic [7:0] v [4] = '{8'h01, 8'h02, 8'h04, 8'hF8};
    logic [2:0] u [4] = '{3'h2, 3'h3, 3'h5, 3'h7};
    wr(BGLUE_OFS_REV, 8'hFF);
    rchk(BGLUE_OFS_REV, 8'hC5);
    foreach (v[i]) begin
      wr(BGLUE_OFS_MISC, v[i]);
      rchk(BGLUE_OFS_MISC, v[i]);
      chk({a19, rt_d, rt_c}, v[i] & 8'h07);
    end
    foreach (u[i]) begin
      wr(u[i], 8'hFF);
      rchk(u[i], BGLUE_UNMAPPED);
    end
    rchk(BGLUE_OFS_MISC, 8'hF8);
  endtask : t_regs
  task automatic t_glue();
    logic [7:0] q;
    logic ok;
    bglue_host_inst.acc(1'b0, 22'h000006, 8'h00, q, ok);
    chk({7'h0, ok}, 8'h00);
    btn_n = 1'b0;
    repeat (5) @(negedge clk);
    chk({7'h0, board_n}, 8'h00);
    btn_n = 1'b1;
    sup_n = 1'b1;
    repeat (5) @(negedge clk);
    chk({7'h0, board_n}, 8'h00);
    sup_n = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({lamp, crst_n, board_n, 2'h0}, 8'h00);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk({6'h0, crst_n, board_n}, 8'h03);
  endtask : t_glue
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    dip = 4'hF;
    pres_n = 1'b1;
    stat = 2'b00;
    btn_n = 1'b1;
    sup_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_user_card();
    t_regs();
    t_glue();
    finish_test();
  end
endmodule : test_bglue_top
